// ### src/lpmc_low_power_ctrl.sv
/*
 * Low-power mode controller: stop/standby selection on deep-sleep entry,
 * regulator state, wake-up handling and the two power registers on an
 * APB-style slave port.
 * Assumes core-side strobes are on clk_sys; pin-side inputs are async.
 */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Deep sleep with select 0 enters stop.
// - Stop regulator follows low-power bit.
// - Interrupt or event wakes, matching the wait.
// - Stop halts core, peripherals; keeps contents.
// - Stop wake waits oscillator time, plus regulator time if low-power bit set.
// - Resume via interrupt service or directly.
// - Select 1, flag clear: enter standby.
// - Pin edge, RTC, reset pin, watchdog exit standby.
// - Standby stops everything; contents lost.
// - Standby exit takes chip reset time.
// - Control resets zero, cleared on standby wake.
// - Bit 1 selects stop or standby.
// - Bit 2 write clears wake flag later.
// - Bit 3 write one clears standby flag.
// - Bit 4 enables voltage detector.
// - Pin or RTC event sets wake flag.
// - Standby entry sets flag; reset/clear only.
// - Detector bit high when supply below level.
// - Status register survives standby wake.
module lpmc_low_power_ctrl #(
  parameter int OSC_CYC = lpmc_pkg::OSC_START_CYC,
  parameter int REG_CYC = lpmc_pkg::REG_WAKE_CYC,
  parameter int RST_CYC = lpmc_pkg::CHIP_RST_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        coreDeepSleep,
  input  wire logic        waitIntrExec,
  input  wire logic        waitEventExec,
  input  wire logic        irqPending,
  input  wire logic        wakeEvent,
  input  wire logic        wakeupPin,
  input  wire logic        rtcWakeEvt,
  input  wire logic        extResetPinN,
  input  wire logic        watchdogRst,
  input  wire logic        detCompare,
  output logic             regLowPower,
  output logic             coreHalt,
  output logic             periphHalt,
  output logic             memLost,
  output logic             resumeIrq,
  output logic             resumeEvt,
  output logic             chipReset,
  output logic             detEnable,
  output logic [2:0]       detLevel,
  output logic             backupWriteEn
);

  lpmc_pkg::lpmc_state_t st;
  lpmc_pkg::lpmc_state_t nxt;

  logic        setEv;
  logic        wfx;
  logic        acc;
  logic        isCtrl;
  logic        isSts;
  logic        stsRd;
  logic        go;
  logic        stbyExit;
  logic [15:0] stopWakeCnt;
  logic [31:0] ctrlWord;
  logic [31:0] stsWord;

  assign setEv    = (st.pinSy[1] & ~st.pinSy[2]) |
                    (st.rtcSy[1] & ~st.rtcSy[2]);
  assign wfx      = waitIntrExec | waitEventExec;
  assign acc      = psel & penable & ~st.pready;
  assign isCtrl   = (paddr == lpmc_pkg::CTRL_OFS);
  assign isSts    = (paddr == lpmc_pkg::CSTS_OFS);
  assign stsRd    = isSts & ~pwrite;
  // A status register read needs one extra bus cycle before it answers.
  assign go       = acc & (~stsRd | st.stsExtra);
  assign stbyExit = (st.pinSy[1] & ~st.pinSy[2]) | st.rtcSy[1] |
                    ~st.rstSy[1] | st.wdtSy[1];
  // Regulator recovery only counts when it really was in low power.
  assign stopWakeCnt = 16'(OSC_CYC) +
                       (st.ctrl.lpReg ? 16'(REG_CYC) : 16'h0000);

  always_comb begin
    ctrlWord = lpmc_pkg::CTRL_RST;
    ctrlWord[lpmc_pkg::CTRL_LPREG_BIT] = st.ctrl.lpReg;
    ctrlWord[lpmc_pkg::CTRL_PDSEL_BIT] = st.ctrl.pdSel;
    ctrlWord[lpmc_pkg::CTRL_DETEN_BIT] = st.ctrl.detEn;
    ctrlWord[lpmc_pkg::CTRL_LVL_MSB:lpmc_pkg::CTRL_LVL_LSB] = st.ctrl.detLvl;
    ctrlWord[lpmc_pkg::CTRL_BKPWE_BIT] = st.ctrl.bkpWe;
    stsWord = lpmc_pkg::CSTS_RST;
    stsWord[lpmc_pkg::CSTS_WF_BIT]  = st.wakeFlag;
    stsWord[lpmc_pkg::CSTS_SB_BIT]  = st.sbFlag;
    stsWord[lpmc_pkg::CSTS_DET_BIT] = st.detOut;
  end

  always_comb begin
    nxt = st;
    nxt.pinSy = {st.pinSy[1:0], wakeupPin};
    nxt.rtcSy = {st.rtcSy[1:0], rtcWakeEvt};
    nxt.rstSy = {st.rstSy[0], extResetPinN};
    nxt.wdtSy = {st.wdtSy[0], watchdogRst};
    nxt.detSy = {st.detSy[0], detCompare};
    nxt.pready    = 1'b0;
    nxt.pslverr   = 1'b0;
    nxt.wfClr     = 1'b0;
    nxt.resumeIrq = 1'b0;
    nxt.resumeEvt = 1'b0;
    nxt.stsExtra  = acc & stsRd & ~st.stsExtra;

    if (go) begin
      nxt.pready  = 1'b1;
      nxt.pslverr = ~(isCtrl | isSts);
      nxt.prdata  = 32'h00000000;
      if (pwrite && isCtrl) begin
        nxt.ctrl.lpReg  = pwdata[lpmc_pkg::CTRL_LPREG_BIT];
        nxt.ctrl.pdSel  = pwdata[lpmc_pkg::CTRL_PDSEL_BIT];
        nxt.ctrl.detEn  = pwdata[lpmc_pkg::CTRL_DETEN_BIT];
        // Code n selects 2.2 V plus n tenths of a volt.
        nxt.ctrl.detLvl =
          pwdata[lpmc_pkg::CTRL_LVL_MSB:lpmc_pkg::CTRL_LVL_LSB];
        nxt.ctrl.bkpWe  = pwdata[lpmc_pkg::CTRL_BKPWE_BIT];
        nxt.wfClr       = pwdata[lpmc_pkg::CTRL_WFCLR_BIT];
        if (pwdata[lpmc_pkg::CTRL_SBCLR_BIT]) begin
          nxt.sbFlag = 1'b0;
        end
      end else if (!pwrite && isCtrl) begin
        nxt.prdata = ctrlWord;
      end else if (stsRd) begin
        nxt.prdata = stsWord;
      end
    end

    // The clear takes effect one cycle after the write; a pin event in that later
    // cycle still wins, while one in the cycle of the write itself is cleared.
    if (st.wfClr) begin
      nxt.wakeFlag = 1'b0;
    end
    if (setEv) begin
      nxt.wakeFlag = 1'b1;
    end

    nxt.detOut = st.ctrl.detEn & st.detSy[1] &
                 (st.mode != lpmc_pkg::LPMC_STANDBY);

    unique case (st.mode)
      lpmc_pkg::LPMC_RUN: begin
        if (coreDeepSleep && wfx && !st.ctrl.pdSel) begin
          nxt.mode   = lpmc_pkg::LPMC_STOP;
          nxt.intrWait = waitIntrExec;
        end else if (coreDeepSleep && wfx && !st.wakeFlag) begin
          nxt.mode   = lpmc_pkg::LPMC_STANDBY;
          nxt.sbFlag = 1'b1;
        end
      end
      lpmc_pkg::LPMC_STOP: begin
        if (st.intrWait ? irqPending : wakeEvent) begin
          nxt.mode = lpmc_pkg::LPMC_STOP_WAKE;
          nxt.cnt  = stopWakeCnt;
        end
      end
      lpmc_pkg::LPMC_STOP_WAKE: begin
        if (st.cnt <= 16'h0001) begin
          nxt.mode      = lpmc_pkg::LPMC_RUN;
          nxt.cnt       = 16'h0000;
          nxt.resumeIrq = st.intrWait;
          nxt.resumeEvt = ~st.intrWait;
        end else begin
          nxt.cnt = st.cnt - 16'h0001;
        end
      end
      lpmc_pkg::LPMC_STANDBY: begin
        if (stbyExit) begin
          nxt.mode = lpmc_pkg::LPMC_STBY_RST;
          nxt.cnt  = 16'(RST_CYC);
        end
      end
      lpmc_pkg::LPMC_STBY_RST: begin
        if (st.cnt <= 16'h0001) begin
          nxt.mode = lpmc_pkg::LPMC_RUN;
          nxt.cnt  = 16'h0000;
          // Status flags are kept so software can see why it restarted.
          nxt.ctrl = lpmc_pkg::STATE_RST.ctrl;
        end else begin
          nxt.cnt = st.cnt - 16'h0001;
        end
      end
    endcase

    nxt.regLowPower = (nxt.mode == lpmc_pkg::LPMC_STOP) &
                      nxt.ctrl.lpReg;
    nxt.coreHalt    = (nxt.mode != lpmc_pkg::LPMC_RUN);
    nxt.memLost     = (nxt.mode == lpmc_pkg::LPMC_STANDBY) |
                      (nxt.mode == lpmc_pkg::LPMC_STBY_RST);
    nxt.chipReset   = (nxt.mode == lpmc_pkg::LPMC_STBY_RST);
  end

  // Only power-on reset reaches the status flags; standby wake does not.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= lpmc_pkg::STATE_RST;
    end else if (clkEn) begin
      st <= nxt;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign regLowPower   = st.regLowPower;
  assign coreHalt      = st.coreHalt;
  assign periphHalt    = st.coreHalt;
  assign memLost       = st.memLost;
  assign resumeIrq     = st.resumeIrq;
  assign resumeEvt     = st.resumeEvt;
  assign chipReset     = st.chipReset;
  assign detEnable     = st.ctrl.detEn;
  assign detLevel      = st.ctrl.detLvl;
  assign backupWriteEn = st.ctrl.bkpWe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !clkEn);

  sequence s_sleep_req;
    st.mode == lpmc_pkg::LPMC_RUN && coreDeepSleep && wfx;
  endsequence

  sequence s_wf_clear_wr;
    go && pwrite && isCtrl && pwdata[lpmc_pkg::CTRL_WFCLR_BIT];
  endsequence

  a_stop_entry: assert property (
    s_sleep_req ##0 !st.ctrl.pdSel |=> st.mode == lpmc_pkg::LPMC_STOP &&
      coreHalt && regLowPower == st.ctrl.lpReg)
    else $error("stop mode not entered on deep sleep");

  a_stby_entry: assert property (
    s_sleep_req ##0 st.ctrl.pdSel && !st.wakeFlag |=>
      st.mode == lpmc_pkg::LPMC_STANDBY && st.sbFlag && memLost)
    else $error("standby mode not entered");

  a_stop_hold: assert property (
    st.mode == lpmc_pkg::LPMC_STOP |-> coreHalt && periphHalt && !memLost)
    else $error("stop mode must halt and keep contents");

  a_stop_wake: assert property (
    st.mode == lpmc_pkg::LPMC_STOP && (st.intrWait ? irqPending : wakeEvent)
      |=> st.mode == lpmc_pkg::LPMC_STOP_WAKE && st.cnt == $past(stopWakeCnt))
    else $error("stop mode wake source ignored");

  a_wake_resume: assert property (
    st.mode == lpmc_pkg::LPMC_STOP_WAKE && st.cnt == 16'h0001 |=>
      !coreHalt && (resumeIrq == st.intrWait) && (resumeEvt != st.intrWait))
    else $error("wrong resume after stop wake");

  a_stby_exit: assert property (
    st.mode == lpmc_pkg::LPMC_STBY_RST && st.cnt == 16'h0001 |->
      chipReset ##1 !chipReset && ctrlWord == lpmc_pkg::CTRL_RST)
    else $error("standby exit did not clear control");

  a_wf_clear: assert property (
    s_wf_clear_wr ##1 !setEv |=> !st.wakeFlag)
    else $error("wake flag not cleared two cycles after write");

  a_sb_clear: assert property (
    go && pwrite && isCtrl && pwdata[lpmc_pkg::CTRL_SBCLR_BIT] &&
      st.mode == lpmc_pkg::LPMC_RUN && !(coreDeepSleep && wfx) |=> !st.sbFlag)
    else $error("standby flag not cleared");

  a_wf_set: assert property (
    setEv |=> st.wakeFlag)
    else $error("wake event lost");

  a_rsvd_zero: assert property (
    pready && !pslverr |-> prdata[31:9] == 23'h000000)
    else $error("reserved bits read nonzero");

  a_det_off: assert property (
    !st.ctrl.detEn ##1 !st.ctrl.detEn |-> !st.detOut)
    else $error("detector status set while disabled");

endmodule : lpmc_low_power_ctrl

`default_nettype wire

// ### src/lpmc_pkg.sv
/*
 * Shared constants and carrier types of the low-power mode controller:
 * register offsets, field positions, reset values, timing counts, the
 * mode enumeration and the packed state record.
 * Assumes a 100 MHz system clock; timing counts are derived from it.
 */
package lpmc_pkg;

  // Register byte offsets on the peripheral bus.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CSTS_OFS = 8'h04;

  // Power control field positions.
  localparam int CTRL_LPREG_BIT = 0;
  localparam int CTRL_PDSEL_BIT = 1;
  localparam int CTRL_WFCLR_BIT = 2;
  localparam int CTRL_SBCLR_BIT = 3;
  localparam int CTRL_DETEN_BIT = 4;
  localparam int CTRL_LVL_LSB   = 5;
  localparam int CTRL_LVL_MSB   = 7;
  localparam int CTRL_BKPWE_BIT = 8;

  // Control/status field positions.
  localparam int CSTS_WF_BIT  = 0;
  localparam int CSTS_SB_BIT  = 1;
  localparam int CSTS_DET_BIT = 2;

  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CSTS_RST = 32'h00000000;

  // Timing figures; the values are plain defaults.
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_START_NS  = 2000;
  localparam int REG_WAKE_NS   = 5000;
  localparam int CHIP_RST_NS   = 20000;
  localparam int OSC_START_CYC =
    (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REG_WAKE_CYC =
    (REG_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_RST_CYC =
    (CHIP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    LPMC_RUN,
    LPMC_STOP,
    LPMC_STOP_WAKE,
    LPMC_STANDBY,
    LPMC_STBY_RST
  } lpmc_mode_t;

  typedef struct packed {
    logic       bkpWe;
    logic [2:0] detLvl;
    logic       detEn;
    logic       pdSel;
    logic       lpReg;
  } lpmc_ctrl_t;

  typedef struct packed {
    lpmc_mode_t  mode;
    logic        intrWait;
    logic [15:0] cnt;
    lpmc_ctrl_t  ctrl;
    logic        wakeFlag;
    logic        sbFlag;
    logic        detOut;
    logic        wfClr;
    logic [2:0]  pinSy;
    logic [2:0]  rtcSy;
    logic [1:0]  rstSy;
    logic [1:0]  wdtSy;
    logic [1:0]  detSy;
    logic        stsExtra;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        regLowPower;
    logic        coreHalt;
    logic        memLost;
    logic        resumeIrq;
    logic        resumeEvt;
    logic        chipReset;
  } lpmc_state_t;

  localparam lpmc_state_t STATE_RST = '0;

endpackage : lpmc_pkg

// ### dv/lpmc_core_model.sv
/*
 * Behavioural processor core: raises the deep-sleep level and issues one
 * wait-for-interrupt or wait-for-event pulse.
 * Assumes the bench calls goSleep just after a falling clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module lpmc_core_model (
  input  wire logic clk_sys,
  output logic      coreDeepSleep,
  output logic      waitIntrExec,
  output logic      waitEventExec
);
  initial begin
    coreDeepSleep = 1'b0;
    waitIntrExec  = 1'b0;
    waitEventExec = 1'b0;
  end

  // A slow core may set deep sleep some cycles before the instruction.
  task automatic goSleep(input bit useEvtWait, input int lag);
    coreDeepSleep = 1'b1;
    repeat (lag) @(negedge clk_sys);
    waitIntrExec  = !useEvtWait;
    waitEventExec = useEvtWait;
    @(negedge clk_sys);
    waitIntrExec  = 1'b0;
    waitEventExec = 1'b0;
    coreDeepSleep = 1'b0;
  endtask : goSleep
endmodule : lpmc_core_model
`default_nettype wire

// ### dv/testbench.sv
/*
 * Self-checking bench of the low-power mode controller.
 * Assumes short timing parameters so each wake-up stays a few cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int OSC = 2;
  localparam int REG = 3;
  localparam int RST = 4;
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic irqPending = 1'b0, wakeEvent = 1'b0, wakeupPin = 1'b0, errb;
  logic rtcWake = 1'b0, extRstN = 1'b1, wdtRst = 1'b0, detCmp = 1'b0;
  logic coreDeepSleep, waitIntrExec, waitEventExec, regLowPower, coreHalt;
  logic periphHalt, memLost, resumeIrq, resumeEvt, chipReset;
  logic detEnable, backupWriteEn;
  logic [2:0] detLevel;
  int errCount = 0, checksDone = 0, cycles = 0;

  always #5 clk_sys = ~clk_sys;

  lpmc_core_model lpmc_core_model_inst (.clk_sys(clk_sys),
    .coreDeepSleep(coreDeepSleep), .waitIntrExec(waitIntrExec),
    .waitEventExec(waitEventExec));

  lpmc_low_power_ctrl #(.OSC_CYC(OSC), .REG_CYC(REG), .RST_CYC(RST))
    lpmc_low_power_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coreDeepSleep(coreDeepSleep),
    .waitIntrExec(waitIntrExec), .waitEventExec(waitEventExec),
    .irqPending(irqPending), .wakeEvent(wakeEvent),
    .wakeupPin(wakeupPin), .rtcWakeEvt(rtcWake), .extResetPinN(extRstN),
    .watchdogRst(wdtRst), .detCompare(detCmp), .regLowPower(regLowPower),
    .coreHalt(coreHalt), .periphHalt(periphHalt), .memLost(memLost),
    .resumeIrq(resumeIrq), .resumeEvt(resumeEvt),
    .chipReset(chipReset), .detEnable(detEnable),
    .detLevel(detLevel), .backupWriteEn(backupWriteEn));

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrapUp

  task automatic chk(input string what, input logic [31:0] exp, got);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The request stands through the rising edge that samples pready high;
  // only the falling edge after it releases the bus.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(negedge clk_sys);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk_sys);
    penable = 1'b1;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      errCount++;
      $display("mismatch pready expected 1 seen %b", pready);
    end
    rdv = prdata;
    errb = pslverr;
    @(negedge clk_sys);
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdv);
  endtask : rd

  task automatic regsScn();
    rd("ctrl reset", 8'h00, 32'h0);
    rd("csts reset", 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'hFFFFFFFF);
    rd("ctrl mask", 8'h00, 32'h000001F3);
    chk("detEnable", 32'h1, detEnable);
    chk("detLevel", 32'h7, detLevel);
    chk("backupWriteEn", 32'h1, backupWriteEn);
    apb(1'b1, 8'h00, 32'h0);
    rd("ctrl zero", 8'h00, 32'h0);
    chk("backupWriteEn off", 32'h0, backupWriteEn);
    rd("unmapped", 8'h08, 32'h0);
    chk("pslverr", 32'h1, errb);
  endtask : regsScn

  task automatic stopScn(input bit e, input bit lp);
    int n;
    apb(1'b1, 8'h00, {31'h0, lp});
    lpmc_core_model_inst.goSleep(e, lp ? 3 : 0);
    @(negedge clk_sys);
    chk("coreHalt", 32'h1, coreHalt);
    chk("periphHalt", 32'h1, periphHalt);
    chk("memLost", 32'h0, memLost);
    chk("regLowPower", {31'h0, lp}, regLowPower);
    // An interrupt must not end a stop that was entered by an event wait.
    if (e) begin
      irqPending = 1'b1;
      repeat (4) @(negedge clk_sys);
      irqPending = 1'b0;
      chk("wfe stays", 32'h1, coreHalt);
      wakeEvent = 1'b1;
    end else irqPending = 1'b1;
    n = 0;
    do begin @(negedge clk_sys); n++; end
    while (resumeIrq !== 1'b1 && resumeEvt !== 1'b1 && n < 40);
    chk("wake cycles", OSC + (lp ? REG : 0) + 1, n);
    chk("resumeIrq", {31'h0, !e}, resumeIrq);
    chk("resumeEvt", {31'h0, e}, resumeEvt);
    chk("coreHalt low", 32'h0, coreHalt);
    irqPending = 1'b0;
    wakeEvent = 1'b0;
  endtask : stopScn

  task automatic standbyScn();
    int n;
    apb(1'b1, 8'h00, 32'h00000012);
    lpmc_core_model_inst.goSleep(1'b0, 0);
    @(negedge clk_sys);
    chk("standby halt", 32'h1, coreHalt);
    chk("standby lost", 32'h1, memLost);
    wakeupPin = 1'b1;
    n = 0;
    while (chipReset !== 1'b1 && n < 20) begin @(negedge clk_sys); n++; end
    n = 0;
    while (chipReset === 1'b1 && n < 20) begin @(negedge clk_sys); n++; end
    chk("reset cycles", RST, n);
    wakeupPin = 1'b0;
    rd("ctrl after", 8'h00, 32'h0);
    chk("detector cleared", 32'h0, detEnable);
    rd("csts after", 8'h04, 32'h3);
    apb(1'b1, 8'h00, 32'h2);
    lpmc_core_model_inst.goSleep(1'b0, 0);
    @(negedge clk_sys);
    chk("blocked", 32'h0, coreHalt);
    apb(1'b1, 8'h00, 32'h4);
    rd("wf clear", 8'h04, 32'h2);
    apb(1'b1, 8'h00, 32'h8);
    rd("sb clear", 8'h04, 32'h0);
  endtask : standbyScn

  // Source 0 is the RTC line, 1 the reset pin, 2 the watchdog.
  task automatic stbyExitScn(input int src);
    int n;
    apb(1'b1, 8'h00, 32'h00000002);
    lpmc_core_model_inst.goSleep(1'b1, 0);
    @(negedge clk_sys);
    chk("standby by event wait", 32'h1, memLost);
    if (src == 0) rtcWake = 1'b1;
    else if (src == 1) extRstN = 1'b0;
    else wdtRst = 1'b1;
    n = 0;
    while (chipReset !== 1'b1 && n < 20) begin @(negedge clk_sys); n++; end
    chk("exit source", 32'h1, chipReset);
    rtcWake = 1'b0;
    extRstN = 1'b1;
    wdtRst = 1'b0;
    n = 0;
    while (chipReset === 1'b1 && n < 20) begin @(negedge clk_sys); n++; end
    chk("exit reset cycles", RST, n);
    rd("flags after exit", 8'h04, src == 0 ? 32'h3 : 32'h2);
    apb(1'b1, 8'h00, 32'h0000000C);
    rd("flags cleared", 8'h04, 32'h0);
  endtask : stbyExitScn

  task automatic detScn();
    detCmp = 1'b1;
    apb(1'b1, 8'h00, 32'h00000010);
    chk("detector on", 32'h1, detEnable);
    rd("detector below", 8'h04, 32'h4);
    apb(1'b1, 8'h00, 32'h0);
    rd("detector off", 8'h04, 32'h0);
    detCmp = 1'b0;
  endtask : detScn

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      wrapUp();
    end
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    regsScn();
    stopScn(1'b0, 1'b0);
    stopScn(1'b0, 1'b1);
    stopScn(1'b1, 1'b1);
    standbyScn();
    stbyExitScn(0);
    stbyExitScn(1);
    stbyExitScn(2);
    detScn();
    wrapUp();
  end
endmodule : testbench
`default_nettype wire
